// [audio_slot_rx.sv]
// slave serial audio receiver with power sequencing
`timescale 1ns/1ps

// Notes on behaviour
// - supply reset leaves everything powered down
// - clocks at an accepted ratio plus enable start 14 ms power-up
// - stopped clocks finish power-down in 22 us
// - slave only; clock and sync never driven
// - serial data sampled on bit clock rise
// - 24-bit words; 16 MSBs at ratio 32
// - I2S MSB on second rise after sync change
// - sync low left, sync high right
// - slot mode delays capture by bit clocks
// - without delay, capture right after sync
// - format chosen by two slot select pins
// - measure ratio, accept within one, set divider
// - stopped clocks shut output driver off
module audio_slot_rx
    import audio_rx_pkg::*;
#(
    parameter int unsigned PWRUP_CYC  = `PWRUP_CYC,  // power-up length
    parameter int unsigned PWRDN_CYC  = `PWRDN_CYC,  // power-down length
    parameter int unsigned FS_TMO_CYC = `FS_TMO_CYC, // sync idle limit
    parameter int unsigned SLOT_DELAY = `SLOT_DELAY  // slot delay, bclks
) (
    input  wire logic        REF_CLK_I,              // 250 MHz clock
    input  wire logic        SYS_RST_I,              // async reset, high
    input  wire logic        BCLK_I,                 // bit clock pin
    input  wire logic        FRAME_SYNC_I,           // frame sync pin
    input  wire logic        SERIAL_AUDIO_INPUT_I,   // serial data pin
    input  wire logic        ENABLE_I,               // enable pin
    input  wire logic        SLOT_SELECT_PIN_A_I,    // format pin a
    input  wire logic        SLOT_SELECT_PIN_B_I,    // format pin b
    output logic [23:0]      SAMPLE_O,               // received word
    output logic             SAMPLE_VALID_O,         // word strobe
    output logic             DRIVER_EN_O,            // output stage on
    output logic [1:0]       POWER_STATE_O,          // sequencer state
    output logic             RATIO_LOCK_O,           // ratio accepted
    output logic [1:0]       INTERNAL_MASTER_CLOCK_DIV_O, // divider
    output logic [3:0]       INTERNAL_MASTER_CLOCK_MUL_O  // multiplier
);

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    localparam logic [31:0] PWRUP_LAST = 32'(PWRUP_CYC - 1);
    localparam logic [31:0] PWRDN_LAST = 32'(PWRDN_CYC - 1);
    localparam logic [31:0] FS_TMO     = 32'(FS_TMO_CYC);
    localparam logic [8:0]  BCLK_TMO   = 9'(`BCLK_TMO_CYC);
    localparam logic [7:0]  SLOT_SKIP  = 8'(SLOT_DELAY);
    localparam logic [4:0]  LAST_LONG  = 5'(`WORD_BITS - 1);
    localparam logic [4:0]  LAST_SHORT = 5'(`SHORT_BITS - 1);

    logic [2:0]  bclk_s_r;
    logic [2:0]  fs_s_r;
    logic [1:0]  din_s_r;
    logic [1:0]  en_s_r;
    logic [1:0]  sa_s_r;
    logic [1:0]  sb_s_r;
    logic        bclk_rise;
    logic        fs_now;
    logic        din;
    logic        en;
    fmt_t        fmt;
    logic        is_i2s;

    logic        fs_prev_r;
    logic        fs_prev_nxt;
    logic        busy_r;
    logic        busy_nxt;
    logic [7:0]  skip_r;
    logic [7:0]  skip_nxt;
    logic [4:0]  bit_r;
    logic [4:0]  bit_nxt;
    logic [23:0] shift_r;
    logic [23:0] shift_nxt;
    logic        chan_r;
    logic        chan_nxt;
    logic [23:0] sample_r;
    logic [23:0] sample_nxt;
    logic        valid_r;
    logic        valid_nxt;
    logic        frame_start;
    logic        last_bit;
    logic        keep;

    logic [8:0]  bclk_idle_r;
    logic [8:0]  bclk_idle_nxt;
    logic [31:0] fs_idle_r;
    logic [31:0] fs_idle_nxt;
    logic        bclk_stop;
    logic        fs_stop;
    logic        clk_run;

    pwr_t        pwr_r;
    pwr_t        pwr_nxt;
    logic [31:0] pwr_cnt_r;
    logic [31:0] pwr_cnt_nxt;

    logic        ratio_ok;
    logic        ratio_short;
    logic [1:0]  ratio_n1;
    logic [3:0]  ratio_n2;

    // pins are only ever inputs; two flops before any use
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bclk_s_r <= '0;
            fs_s_r   <= '0;
            din_s_r  <= '0;
            en_s_r   <= '0;
            sa_s_r   <= '0;
            sb_s_r   <= '0;
        end else begin
            bclk_s_r <= {bclk_s_r[1:0], BCLK_I};
            fs_s_r   <= {fs_s_r[1:0], FRAME_SYNC_I};
            din_s_r  <= {din_s_r[0], SERIAL_AUDIO_INPUT_I};
            en_s_r   <= {en_s_r[0], ENABLE_I};
            sa_s_r   <= {sa_s_r[0], SLOT_SELECT_PIN_A_I};
            sb_s_r   <= {sb_s_r[0], SLOT_SELECT_PIN_B_I};
        end
    end

    // synchronised levels, bit clock edge and pin format
    assign bclk_rise = bclk_s_r[1] & ~bclk_s_r[2];
    assign fs_now    = fs_s_r[1];
    assign din       = din_s_r[1];
    assign en        = en_s_r[1];
    assign fmt       = fmt_t'({sa_s_r[1], sb_s_r[1]});
    assign is_i2s    = (fmt == FMT_I2S_LEFT) || (fmt == FMT_I2S_RIGHT);

    // I2S starts on any sync change, PCM on the rising marker
    assign frame_start = is_i2s ? (fs_now != fs_prev_r)
                                : (fs_now & ~fs_prev_r);
    assign last_bit    = ratio_short ? (bit_r == LAST_SHORT)
                                     : (bit_r == LAST_LONG);
    // sync low is left, high is right; keep the selected one
    assign keep = is_i2s ? (chan_r == (fmt == FMT_I2S_RIGHT))
                         : 1'b1;

    // serial word capture on bit clock rising edges
    always_comb begin
        fs_prev_nxt = fs_prev_r;
        busy_nxt    = busy_r;
        skip_nxt    = skip_r;
        bit_nxt     = bit_r;
        shift_nxt   = shift_r;
        chan_nxt    = chan_r;
        sample_nxt  = sample_r;
        valid_nxt   = 1'b0;
        if (pwr_r != ST_ON) begin
            sample_nxt = '0;
        end
        if (bclk_rise) begin
            fs_prev_nxt = fs_now;
            // finish the running word first: its last bit can share
            // the edge on which the next frame starts
            if (busy_r) begin
                if (skip_r != 8'h00) begin
                    skip_nxt = skip_r - 8'h01;
                end else begin
                    shift_nxt = {shift_r[22:0], din};
                    bit_nxt   = bit_r + 5'h01;
                    if (last_bit) begin
                        busy_nxt = 1'b0;
                        if (keep && pwr_r == ST_ON) begin
                            valid_nxt  = 1'b1;
                            sample_nxt = ratio_short
                                ? {shift_r[14:0], din, 8'h00}
                                : {shift_r[22:0], din};
                        end
                    end
                end
            end
            if (frame_start) begin
                busy_nxt  = 1'b1;
                bit_nxt   = '0;
                shift_nxt = '0;
                chan_nxt  = fs_now;
                skip_nxt  = (fmt == FMT_PCM_SLOT) ? SLOT_SKIP
                                                  : 8'h00;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            fs_prev_r <= 1'b0;
            busy_r    <= 1'b0;
            skip_r    <= '0;
            bit_r     <= '0;
            shift_r   <= '0;
            chan_r    <= 1'b0;
            sample_r  <= '0;
            valid_r   <= 1'b0;
        end else begin
            fs_prev_r <= fs_prev_nxt;
            busy_r    <= busy_nxt;
            skip_r    <= skip_nxt;
            bit_r     <= bit_nxt;
            shift_r   <= shift_nxt;
            chan_r    <= chan_nxt;
            sample_r  <= sample_nxt;
            valid_r   <= valid_nxt;
        end
    end

    // idle counters that notice stopped bit clock or frame sync
    always_comb begin
        bclk_idle_nxt = bclk_idle_r;
        fs_idle_nxt   = fs_idle_r;
        if (bclk_rise) begin
            bclk_idle_nxt = '0;
        end else if (bclk_idle_r != BCLK_TMO) begin
            bclk_idle_nxt = bclk_idle_r + 9'h001;
        end
        if (fs_s_r[1] != fs_s_r[2]) begin
            fs_idle_nxt = '0;
        end else if (fs_idle_r != FS_TMO) begin
            fs_idle_nxt = fs_idle_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bclk_idle_r <= BCLK_TMO;
            fs_idle_r   <= FS_TMO;
        end else begin
            bclk_idle_r <= bclk_idle_nxt;
            fs_idle_r   <= fs_idle_nxt;
        end
    end

    assign bclk_stop = (bclk_idle_r == BCLK_TMO);
    assign fs_stop   = (fs_idle_r == FS_TMO);
    assign clk_run   = ~bclk_stop & ~fs_stop & ratio_ok;

    // ratio measurement on frame marks seen at bit clock edges
    bclk_ratio_detect u_ratio (
        .clk_i       (REF_CLK_I),
        .rst_i       (SYS_RST_I),
        .bclk_rise_i (bclk_rise),
        .frame_i     (fs_now & ~fs_prev_r),
        .clear_i     (bclk_stop | fs_stop),
        .ok_o        (ratio_ok),
        .short_o     (ratio_short),
        .n1_o        (ratio_n1),
        .n2_o        (ratio_n2)
    );

    // power sequencer: down, timed up, on, timed off
    always_comb begin
        pwr_nxt     = pwr_r;
        pwr_cnt_nxt = pwr_cnt_r;
        case (pwr_r)
            ST_DOWN: begin
                if (en && clk_run) begin
                    pwr_nxt     = ST_UP;
                    pwr_cnt_nxt = '0;
                end
            end
            ST_UP: begin
                if (!en || !clk_run) begin
                    pwr_nxt     = ST_OFF;
                    pwr_cnt_nxt = '0;
                end else if (pwr_cnt_r == PWRUP_LAST) begin
                    pwr_nxt     = ST_ON;
                    pwr_cnt_nxt = '0;
                end else begin
                    pwr_cnt_nxt = pwr_cnt_r + 32'h0000_0001;
                end
            end
            ST_ON: begin
                if (!en || !clk_run) begin
                    pwr_nxt     = ST_OFF;
                    pwr_cnt_nxt = '0;
                end
            end
            ST_OFF: begin
                if (pwr_cnt_r == PWRDN_LAST) begin
                    pwr_nxt     = ST_DOWN;
                    pwr_cnt_nxt = '0;
                end else begin
                    pwr_cnt_nxt = pwr_cnt_r + 32'h0000_0001;
                end
            end
            default: begin
                pwr_nxt     = ST_DOWN;
                pwr_cnt_nxt = '0;
            end
        endcase
    end

    // reset lands in the powered-down state
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pwr_r     <= ST_DOWN;
            pwr_cnt_r <= '0;
        end else begin
            pwr_r     <= pwr_nxt;
            pwr_cnt_r <= pwr_cnt_nxt;
        end
    end

    // outputs
    assign SAMPLE_O                    = sample_r;
    assign SAMPLE_VALID_O              = valid_r;
    assign DRIVER_EN_O                 = (pwr_r == ST_ON);
    assign POWER_STATE_O               = pwr_r;
    assign RATIO_LOCK_O                = ratio_ok;
    assign INTERNAL_MASTER_CLOCK_DIV_O = ratio_n1;
    assign INTERNAL_MASTER_CLOCK_MUL_O = ratio_n2;

    // checks
    pwr_reset_a: assert property (
        $fell(SYS_RST_I) |-> (pwr_r == ST_DOWN && !DRIVER_EN_O))
        else $error("not powered down after reset");

    pwrup_time_a: assert property (
        $rose(DRIVER_EN_O) |->
            ($past(pwr_r) == ST_UP && $past(pwr_cnt_r) == PWRUP_LAST))
        else $error("driver on before full power-up time");

    pwrdn_time_a: assert property (
        (pwr_r == ST_OFF && pwr_cnt_r == PWRDN_LAST) |=> pwr_r == ST_DOWN)
        else $error("power-down did not end on time");

    clkstop_off_a: assert property (
        (pwr_r == ST_ON && !clk_run) |=> (!DRIVER_EN_O && pwr_r == ST_OFF))
        else $error("driver stayed on with clocks stopped");

    rise_sample_a: assert property (
        $changed(shift_r) |-> $past(bclk_rise))
        else $error("data shifted without bit clock rise");

    short_word_a: assert property (
        (SAMPLE_VALID_O && $past(ratio_short)) |-> SAMPLE_O[7:0] == 8'h00)
        else $error("short word carries low bits");

    i2s_msb_a: assert property (
        (bclk_rise && frame_start && is_i2s) |=>
            (busy_r && skip_r == 8'h00 && bit_r == 5'h00))
        else $error("I2S msb not taken on next rise");

    slot_delay_a: assert property (
        (bclk_rise && frame_start && fmt == FMT_PCM_SLOT) |=>
            skip_r == SLOT_SKIP)
        else $error("slot delay not loaded");

    pcm_now_a: assert property (
        (bclk_rise && frame_start && fmt == FMT_PCM) |=> skip_r == 8'h00)
        else $error("undelayed PCM capture delayed");

    chan_keep_a: assert property (
        (SAMPLE_VALID_O && ($past(fmt) == FMT_I2S_LEFT ||
                            $past(fmt) == FMT_I2S_RIGHT)) |->
            $past(chan_r) == ($past(fmt) == FMT_I2S_RIGHT))
        else $error("wrong I2S channel delivered");

    power_on_c: cover property ($rose(DRIVER_EN_O));
    slot_word_c: cover property (SAMPLE_VALID_O && fmt == FMT_PCM_SLOT);
    i2s_right_c: cover property (SAMPLE_VALID_O && fmt == FMT_I2S_RIGHT);
    power_down_c: cover property (pwr_r == ST_OFF ##1 pwr_r == ST_DOWN);

endmodule

// [audio_rx_map.svh]
// timing figures, word sizes and ratio table of the serial audio receiver
`ifndef AUDIO_RX_MAP_SVH
`define AUDIO_RX_MAP_SVH

`define CLK_MHZ       250
`define PWRUP_MS      14
`define PWRUP_CYC     (`PWRUP_MS * `CLK_MHZ * 1000)
`define PWRDN_US      22
`define PWRDN_CYC     (`PWRDN_US * `CLK_MHZ)
`define BCLK_TMO_NS   1000
`define BCLK_TMO_CYC  ((`BCLK_TMO_NS * `CLK_MHZ) / 1000)
`define FS_TMO_US     130
`define FS_TMO_CYC    (`FS_TMO_US * `CLK_MHZ)
`define WORD_BITS     24
`define SHORT_BITS    16
`define SHORT_RATIO   32
`define RATIO_TOL     1
`define SLOT_DELAY    16
`define CNT_SAT       10'h3FE
`define RATIO_ENTRIES 11
`define RATIO_TABLE   '{'{10'h020, 2'h1, 4'h8}, '{10'h032, 2'h1, 4'h8}, \
                        '{10'h040, 2'h2, 4'h8}, '{10'h064, 2'h2, 4'h8}, \
                        '{10'h07D, 2'h2, 4'h8}, '{10'h080, 2'h2, 4'h4}, \
                        '{10'h0C8, 2'h2, 4'h4}, '{10'h0FA, 2'h2, 4'h4}, \
                        '{10'h100, 2'h1, 4'h1}, '{10'h190, 2'h1, 4'h1}, \
                        '{10'h1F4, 2'h1, 4'h1}}

`endif

// [audio_rx_pkg.sv]
// types and ratio lookup of the serial audio receiver
`include "audio_rx_map.svh"

package audio_rx_pkg;

    // pin selected interface format
    typedef enum logic [1:0] {FMT_I2S_LEFT, FMT_I2S_RIGHT,
                              FMT_PCM, FMT_PCM_SLOT} fmt_t;

    // power sequencer states
    typedef enum logic [1:0] {ST_DOWN, ST_UP, ST_ON, ST_OFF} pwr_t;

    typedef struct packed {
        logic [9:0] nominal;
        logic [1:0] n1;
        logic [3:0] n2;
    } ratio_ent_t;

    typedef struct packed {
        logic       ok;
        logic       short_word;
        logic [1:0] n1;
        logic [3:0] n2;
    } ratio_info_t;

    localparam ratio_ent_t RATIO_TBL [`RATIO_ENTRIES] = `RATIO_TABLE;

    // match a measured ratio against the table within the tolerance
    function automatic ratio_info_t ratio_lookup(input logic [9:0] meas);
        ratio_info_t info;
        logic [10:0] lo;
        logic [10:0] hi;
        info = '0;
        for (int i = 0; i < `RATIO_ENTRIES; i++) begin
            lo = {1'b0, meas} + 11'(`RATIO_TOL);
            hi = {1'b0, RATIO_TBL[i].nominal} + 11'(`RATIO_TOL);
            if (lo >= {1'b0, RATIO_TBL[i].nominal} && {1'b0, meas} <= hi) begin
                info.ok         = 1'b1;
                info.short_word = (RATIO_TBL[i].nominal == 10'(`SHORT_RATIO));
                info.n1         = RATIO_TBL[i].n1;
                info.n2         = RATIO_TBL[i].n2;
            end
        end
        return info;
    endfunction

endpackage

// [bclk_ratio_detect.sv]
// bit clocks per frame measurement and clock divider selection
`timescale 1ns/1ps

module bclk_ratio_detect
    import audio_rx_pkg::*;
(
    input  wire logic       clk_i,       // reference clock
    input  wire logic       rst_i,       // async reset, high
    input  wire logic       bclk_rise_i, // bit clock rising edge pulse
    input  wire logic       frame_i,     // frame mark on this edge
    input  wire logic       clear_i,     // clocks stopped
    output logic            ok_o,        // ratio accepted
    output logic            short_o,     // ratio of 32
    output logic [1:0]      n1_o,        // master clock divider
    output logic [3:0]      n2_o         // master clock multiplier
);

    logic [9:0]  cnt_r;
    logic [9:0]  cnt_nxt;
    logic        seen_r;
    logic        seen_nxt;
    ratio_info_t info_r;
    ratio_info_t info_nxt;
    ratio_info_t meas_info;

    // count edges between frame marks, judge at each mark after the first
    always_comb begin
        meas_info = ratio_lookup(cnt_r + 10'h001);
        cnt_nxt   = cnt_r;
        seen_nxt  = seen_r;
        info_nxt  = info_r;
        if (clear_i) begin
            cnt_nxt  = '0;
            seen_nxt = 1'b0;
            info_nxt = '0;
        end else if (bclk_rise_i) begin
            if (frame_i) begin
                cnt_nxt  = '0;
                seen_nxt = 1'b1;
                if (seen_r) begin
                    info_nxt = meas_info;
                end
            end else if (cnt_r != `CNT_SAT) begin
                cnt_nxt = cnt_r + 10'h001;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            seen_r <= 1'b0;
            info_r <= '0;
        end else begin
            cnt_r  <= cnt_nxt;
            seen_r <= seen_nxt;
            info_r <= info_nxt;
        end
    end

    assign ok_o    = info_r.ok;
    assign short_o = info_r.short_word;
    assign n1_o    = info_r.n1;
    assign n2_o    = info_r.n2;

    // lock only ever appears right after a measured frame
    ratio_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ok_o) |-> $past(frame_i && bclk_rise_i && seen_r))
        else $error("ratio lock without a measured frame");

endmodule

// [audio_ctrl_model.sv]
// behavioural audio controller: bit clock, frame sync and serial data
`timescale 1ns/1ps

module audio_ctrl_model #(
    parameter int HALF_NS = 20               // bit clock half period
) (
    input  wire logic        run_i,          // let clocks run
    input  wire logic        pcm_i,          // pcm framing, else i2s
    input  wire logic [9:0]  ratio_i,        // bit clocks per frame
    input  wire logic [7:0]  skip_i,         // pcm slot delay
    input  wire logic [23:0] left_i,         // left or pcm word
    input  wire logic [23:0] right_i,        // right word
    output logic             bclk_o,         // bit clock
    output logic             fs_o,           // frame sync
    output logic             data_o          // serial data
);
    int          half;
    int          rel;
    int          b;
    int          n;
    logic        pcm;
    logic [7:0]  skip;
    logic [23:0] w;

    // whole frames only; clocks stand still while run_i is low
    initial begin
        bclk_o = 1'b0;
        fs_o   = 1'b0;
        data_o = 1'b0;
        forever begin
            if (!run_i) begin
                #(2 * HALF_NS) data_o = ~data_o; // released line
            end else begin
                n    = int'(ratio_i);            // we make both clocks
                half = n / 2;
                pcm  = pcm_i;
                skip = skip_i;
                for (int r = 0; r < n; r++) begin
                    #5;                          // change off the ref edge
                    rel = (r >= half) ? r - half : r;
                    if (pcm) begin
                        fs_o = (r == 0);
                        w    = left_i;
                        b    = r - 1 - int'(skip);
                    end else begin
                        fs_o = (r >= half);
                        w    = ((r >= half) ^ (rel == 0)) ? right_i : left_i;
                        b    = (rel == 0) ? half - 1 : rel - 1;
                    end
                    data_o = (b >= 0 && b < 24) ? w[23 - b] : ~data_o;
                    #(HALF_NS - 5) bclk_o = 1'b1;
                    #HALF_NS bclk_o = 1'b0;
                end
            end
        end
    end
endmodule

// [audio_slot_rx_tb.sv]
// self-checking testbench of the serial audio receiver
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    n_fail++; $display("wrong value %s exp %0h got %0h", nm, ex, got); \
    end end

module audio_slot_rx_tb
    import audio_rx_pkg::*;
;
    localparam int          PWRUP = 200;
    localparam int          PWRDN = 50;
    localparam int          SLOT  = 5;
    localparam logic [23:0] LW    = 24'hA5C3E1;
    localparam logic [23:0] RW    = 24'h3C5A96;

    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        en    = 1'b0;
    logic        pin_a = 1'b0;
    logic        pin_b = 1'b0;
    logic        run   = 1'b0;
    logic        pcm   = 1'b0;
    logic [9:0]  ratio = 10'h040;
    logic [7:0]  skip  = 8'h00;
    logic [23:0] left  = LW;
    logic [23:0] right = RW;
    logic        bclk;
    logic        fs;
    logic        sdata;
    logic [23:0] sample;
    logic        valid;
    logic        drv;
    logic [1:0]  pstate;
    logic        lock;
    logic [1:0]  div;
    logic [3:0]  mul;
    int          n_fail   = 0;
    int          n_checks = 0;

    // 250 MHz reference
    always #2 clk = ~clk;

    audio_slot_rx #(.PWRUP_CYC(PWRUP), .PWRDN_CYC(PWRDN),
                    .FS_TMO_CYC(2000), .SLOT_DELAY(SLOT)) DUT (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .BCLK_I(bclk),
        .FRAME_SYNC_I(fs), .SERIAL_AUDIO_INPUT_I(sdata), .ENABLE_I(en),
        .SLOT_SELECT_PIN_A_I(pin_a), .SLOT_SELECT_PIN_B_I(pin_b),
        .SAMPLE_O(sample), .SAMPLE_VALID_O(valid), .DRIVER_EN_O(drv),
        .POWER_STATE_O(pstate), .RATIO_LOCK_O(lock),
        .INTERNAL_MASTER_CLOCK_DIV_O(div), .INTERNAL_MASTER_CLOCK_MUL_O(mul));

    audio_ctrl_model ctrl (
        .run_i(run), .pcm_i(pcm), .ratio_i(ratio), .skip_i(skip),
        .left_i(left), .right_i(right), .bclk_o(bclk), .fs_o(fs),
        .data_o(sdata));

    // advance k edges, then step off the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // count cycles until the sequencer shows state s
    task automatic wait_state(input logic [1:0] s, input int lim,
                              output int n);
        n = 0;
        while (pstate !== s && n < lim) begin
            step(1);
            n++;
        end
        `CHK("power state", s, pstate)
    endtask

    // drop skip_n strobes, then return the next word
    task automatic get_word(input int skip_n, output logic [23:0] w);
        int k;
        for (int i = 0; i <= skip_n; i++) begin
            k = 0;
            step(1);
            while (valid !== 1'b1 && k < 4000) begin
                step(1);
                k++;
            end
            w = sample;
        end
        `CHK("word strobe", 1'b1, valid)
    endtask

    // start clocks, check lock and power-up length
    task automatic power_up(input logic [9:0] rt, input logic p,
                            input logic [1:0] dv, input logic [3:0] ml);
        int n;
        ratio = rt;
        pcm   = p;
        run   = 1'b1;
        wait_state(ST_UP, 6000, n);
        `CHK("lock", 1'b1, lock)
        `CHK("divider", dv, div)
        `CHK("multiplier", ml, mul)
        wait_state(ST_ON, PWRUP + 5, n);
        `CHK("power-up length", 1'b1, n >= PWRUP && n <= PWRUP + 1)
        `CHK("driver on", 1'b1, drv)
    endtask

    // silence, stop clocks, check shutdown and its length
    task automatic power_down;
        int n;
        left  = '0;
        right = '0;
        step(4 * 640);                     // short zero flush
        run = 1'b0;
        wait_state(ST_OFF, 1500, n);
        `CHK("driver off", 1'b0, drv)
        wait_state(ST_DOWN, PWRDN + 5, n);
        `CHK("power-down length", 1'b1, n >= PWRDN && n <= PWRDN + 1)
        `CHK("muted word", 24'h0, sample)
        left  = LW;
        right = RW;
    endtask

    // powered down after reset; enable alone does nothing
    task automatic t_reset;
        `CHK("state at reset", ST_DOWN, pstate)
        `CHK("driver at reset", 1'b0, drv)
        en = 1'b1;
        step(1000);
        `CHK("no clocks, no power", ST_DOWN, pstate)
    endtask

    // i2s left then right channel kept
    task automatic t_i2s;
        logic [23:0] w;
        power_up(10'h040, 1'b0, 2'h2, 4'h8);
        get_word(1, w);
        `CHK("left word", LW, w)
        pin_b = 1'b1;
        get_word(2, w);
        `CHK("right word", RW, w)
    endtask

    // pcm without and with slot delay, ratio at tolerance edge
    task automatic t_pcm;
        logic [23:0] w;
        pin_a = 1'b1;
        pin_b = 1'b0;
        power_up(10'h041, 1'b1, 2'h2, 4'h8);
        get_word(1, w);
        `CHK("pcm word", LW, w)
        pin_b = 1'b1;
        skip  = 8'(SLOT);
        get_word(2, w);
        `CHK("delayed slot word", LW, w)
    endtask

    // ratio 32 keeps the 16 top bits only
    task automatic t_short;
        logic [23:0] w;
        pin_a = 1'b0;
        pin_b = 1'b0;
        skip  = 8'h00;
        power_up(10'h020, 1'b0, 2'h1, 4'h8);
        get_word(1, w);
        `CHK("short word", {LW[23:8], 8'h00}, w)
    endtask

    // unsupported ratio never locks nor powers up
    task automatic t_bad_ratio;
        ratio = 10'h050;
        run   = 1'b1;
        step(4000);
        `CHK("odd ratio lock", 1'b0, lock)
        `CHK("odd ratio state", ST_DOWN, pstate)
        run = 1'b0;
    endtask

    // verdict and end of run
    task automatic conclude;
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        step(16);
        rst = 1'b0;
        t_reset();
        t_i2s();
        power_down();
        t_pcm();
        power_down();
        t_short();
        power_down();
        t_bad_ratio();
        conclude();
    end

    // watchdog against a hang
    initial begin
        #400_000;
        n_fail++;
        conclude();
    end
endmodule
